// >>> rtl/sleep_mode_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - mode codes zero to six accepted
// - mode zero never sleeps, stays awake
// - option bit0 clear polls on cyclic wake
// - option bit1 clear samples on wake if adc_sampling_en is set
// - period in 10 ms units, max 0x68b0
// - period expiry wakes, then may sleep again
// - period used only in modes four-six
// - coordinator discards held message after 2.5 periods
// - idle time in ms, 1 to 0xffff
// - idle timer only in modes four, five
module sleep_mode_control #(
    parameter int unsigned CYC_PER_MS = sleep_ctrl_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // command port
    input  wire sleep_ctrl_pkg::cmd_t  cmd,
    output sleep_ctrl_pkg::rsp_t       rsp,
    // traffic indications
    input  wire logic                  serial_activity,
    input  wire logic                  radio_activity,
    // sleep request pin, asynchronous
    input  wire logic                  sleep_pin,
    // configuration levels
    input  wire logic                  adc_sampling_en,
    input  wire logic                  coordinator_enable,
    // indirect message tracking
    input  wire logic                  msg_queued,
    input  wire logic                  msg_delivered,
    // status
    output logic                       asleep,
    output logic                       poll_req,
    output logic                       sample_req,
    output logic                       msg_discard,
    output logic                       msg_holding
);
    import sleep_ctrl_pkg::*;

    ctrl_state_t q;            // registered state
    ctrl_state_t d;            // next state
    logic        tick_ms;      // one ms elapsed
    logic        tick_period;  // one period unit elapsed
    logic        activity;     // any serial or radio transfer
    logic        pin_fell;     // synchronised pin release
    logic        hold_on;      // coordinator hold is active

    // modes driven by the pin level
    function automatic logic pin_mode(input logic [7:0] m);
        return (m == MODE_PIN_HIBERNATE) || (m == MODE_PIN_DOZE);
    endfunction

    // modes that run the inactivity timer
    function automatic logic timer_mode(input logic [7:0] m);
        return (m == MODE_CYCLIC) || (m == MODE_CYCLIC_PIN);
    endfunction

    // modes in which the period counts
    function automatic logic period_mode(input logic [7:0] m);
        return timer_mode(m) || (m == MODE_COORD);
    endfunction

    sleep_timebase #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timebase (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .tick_ms     (tick_ms),
        .tick_period (tick_period)
    );

    assign activity = serial_activity | radio_activity;
    assign pin_fell = q.pin_s3 & ~q.pin_s2;
    assign hold_on  = ((q.mode == MODE_COORD) || coordinator_enable)
                      && period_mode(q.mode) && (q.period != '0);

    // next-state logic
    always_comb begin
        d             = q;
        d.poll_req    = 1'b0;
        d.sample_req  = 1'b0;
        d.msg_discard = 1'b0;
        d.rsp         = '0;
        // pin synchroniser
        d.pin_s1      = sleep_pin;
        d.pin_s2      = q.pin_s1;
        d.pin_s3      = q.pin_s2;

        // command handling
        if (cmd.valid) begin
            d.rsp.valid = 1'b1;
            case (cmd.sel)
                sleep_mode_command: begin
                    d.rsp.data = {8'h00, q.mode};
                    if (cmd.write) begin
                        if (cmd.data <= {8'h00, MODE_MAX}) begin
                            d.mode = cmd.data[7:0];
                        end else begin
                            d.rsp.error = 1'b1;
                        end
                    end
                end
                sleep_options_command: begin
                    d.rsp.data = {8'h00, q.opts};
                    if (cmd.write) begin
                        if (cmd.data <= {8'h00, OPT_MAX}) begin
                            d.opts = cmd.data[7:0];
                        end else begin
                            d.rsp.error = 1'b1;
                        end
                    end
                end
                sleep_period_command: begin
                    d.rsp.data = q.period;
                    if (cmd.write) begin
                        if (cmd.data <= PERIOD_MAX) begin
                            d.period = cmd.data;
                        end else begin
                            d.rsp.error = 1'b1;
                        end
                    end
                end
                idle_time_command: begin
                    d.rsp.data = q.idle;
                    if (cmd.write) begin
                        if (cmd.data >= IDLE_MIN) begin
                            d.idle = cmd.data;
                        end else begin
                            d.rsp.error = 1'b1;
                        end
                    end
                end
                default: d.rsp.error = 1'b1;
            endcase
        end

        // sleep state machine
        case (q.pwr)
            pwr_awake: begin
                if (!timer_mode(q.mode) || activity) begin
                    d.idle_cnt = q.idle;
                end else if (tick_ms && (q.idle_cnt != '0)) begin
                    d.idle_cnt = q.idle_cnt - 16'h0001;
                end
                if (pin_mode(q.mode) && q.pin_s2) begin
                    d.pwr = pwr_asleep;
                end else if (timer_mode(q.mode) && (q.idle_cnt == '0) && !activity) begin
                    d.pwr       = pwr_asleep;
                    d.sleep_cnt = '0;
                end
            end
            pwr_asleep: begin
                if (pin_mode(q.mode)) begin
                    if (!q.pin_s2) begin
                        d.pwr        = pwr_awake;
                        d.sample_req = ~q.opts[OPT_SAMPLE_DIS_BIT] & adc_sampling_en;
                    end
                end else if (timer_mode(q.mode)) begin
                    if (q.sleep_cnt >= q.period) begin
                        d.pwr        = pwr_awake;
                        d.idle_cnt   = q.idle;
                        d.poll_req   = ~q.opts[OPT_POLL_DIS_BIT];
                        d.sample_req = ~q.opts[OPT_SAMPLE_DIS_BIT] & adc_sampling_en;
                    end else if ((q.mode == MODE_CYCLIC_PIN) && pin_fell) begin
                        d.pwr        = pwr_awake;
                        d.idle_cnt   = q.idle;
                        d.sample_req = ~q.opts[OPT_SAMPLE_DIS_BIT] & adc_sampling_en;
                    end else if (tick_period) begin
                        d.sleep_cnt = q.sleep_cnt + 16'h0001;
                    end
                end else begin
                    d.pwr = pwr_awake;
                end
            end
            default: d.pwr = pwr_awake;
        endcase
        d.asleep = (d.pwr == pwr_asleep);

        // indirect message hold timer; a new message wins over a delivery
        if (!hold_on) begin
            d.hold     = 1'b0;
            d.hold_cnt = '0;
        end else if (msg_queued && (!q.hold || msg_delivered)) begin
            d.hold     = 1'b1;
            d.hold_cnt = '0;
        end else if (msg_delivered) begin
            d.hold     = 1'b0;  // delivery beats discard
            d.hold_cnt = '0;
        end else if (q.hold) begin
            if ({1'b0, q.hold_cnt, 1'b0} >= 19'(q.period) * HOLD_MUL) begin
                d.hold        = 1'b0;
                d.hold_cnt    = '0;
                d.msg_discard = 1'b1;
            end else if (tick_period) begin
                d.hold_cnt = q.hold_cnt + 17'h00001;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign rsp         = q.rsp;
    assign asleep      = q.asleep;
    assign poll_req    = q.poll_req;
    assign sample_req  = q.sample_req;
    assign msg_discard = q.msg_discard;
    assign msg_holding = q.hold;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_MODE_RANGE: assert property (q.mode <= MODE_MAX)
        else $error("mode out of range");
    AST_DISABLED_AWAKE: assert property ((q.mode == MODE_DISABLED) [*2] |-> !asleep)
        else $error("asleep in disabled mode");
    AST_POLL_OPTION: assert property (poll_req |-> !$past(q.opts[OPT_POLL_DIS_BIT]) && $fell(asleep))
        else $error("poll despite disable or without wake");
    AST_SAMPLE_OPTION: assert property (sample_req |-> !$past(q.opts[OPT_SAMPLE_DIS_BIT]) && $fell(asleep))
        else $error("sample despite disable");
    AST_PERIOD_RANGE: assert property (q.period <= PERIOD_MAX)
        else $error("period out of range");
    AST_TIMER_WAKE: assert property ($fell(asleep) && timer_mode($past(q.mode)) && !$past(pin_fell)
                                     |-> $past(q.sleep_cnt) >= $past(q.period))
        else $error("woke before period expired");
    AST_SLEEP_MODES: assert property ($rose(asleep) |-> $past(pin_mode(q.mode) || timer_mode(q.mode)))
        else $error("slept in a mode without sleep");
    AST_DISCARD_TIME: assert property (msg_discard |-> $past(q.period) != '0
        && {1'b0, $past(q.hold_cnt), 1'b0} >= 19'($past(q.period)) * HOLD_MUL)
        else $error("discard before 2.5 periods");
    AST_IDLE_NONZERO: assert property (q.idle >= IDLE_MIN)
        else $error("idle time zero");
    AST_REJECT_KEEPS: assert property (rsp.valid && rsp.error
        |-> $stable(q.mode) && $stable(q.opts) && $stable(q.period) && $stable(q.idle))
        else $error("rejected write changed a value");

endmodule // sleep_mode_control

// >>> rtl/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;

    // timebase
    localparam int unsigned CLK_PERIOD_NS      = 20;       // core clock period in ns
    localparam int unsigned MS_NS              = 1000000;  // one millisecond in ns
    localparam int unsigned CYCLES_PER_MS      = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_PERIOD_UNIT = 10;       // sleep period unit in ms

    // sleep mode codes
    localparam logic [7:0] MODE_DISABLED      = 8'h00;
    localparam logic [7:0] MODE_PIN_HIBERNATE = 8'h01;
    localparam logic [7:0] MODE_PIN_DOZE      = 8'h02;
    localparam logic [7:0] MODE_CYCLIC        = 8'h04;
    localparam logic [7:0] MODE_CYCLIC_PIN    = 8'h05;
    localparam logic [7:0] MODE_COORD         = 8'h06;
    localparam logic [7:0] MODE_MAX           = 8'h06;

    // sleep options
    localparam logic [7:0] OPT_MAX            = 8'h04;
    localparam int unsigned OPT_POLL_DIS_BIT   = 0;  // skip wake-up poll
    localparam int unsigned OPT_SAMPLE_DIS_BIT = 1;  // skip wake-up sample

    // period and idle limits
    localparam logic [15:0] PERIOD_MAX = 16'h68b0;
    localparam logic [15:0] IDLE_MIN   = 16'h0001;
    localparam logic [18:0] HOLD_MUL   = 19'h00005;  // 2.5 x period, compared doubled

    // reset values
    localparam logic [7:0]  MODE_RESET   = 8'h00;
    localparam logic [7:0]  OPT_RESET    = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'h0064;
    localparam logic [15:0] IDLE_RESET   = 16'h1388;

    // parameter selector of the command port
    typedef enum logic [1:0] {
        sleep_mode_command,
        sleep_options_command,
        sleep_period_command,
        idle_time_command
    } param_sel_t;

    // command from host
    typedef struct packed {
        logic        valid;  // one-cycle request
        logic        write;  // 1 write, 0 read
        param_sel_t  sel;    // parameter addressed
        logic [15:0] data;   // write value
    } cmd_t;

    // answer to host
    typedef struct packed {
        logic        valid;  // one-cycle answer
        logic        error;  // write rejected
        logic [15:0] data;   // parameter value
    } rsp_t;

    typedef enum logic {
        pwr_awake,
        pwr_asleep
    } power_state_t;

    // whole state of the controller
    typedef struct packed {
        logic [7:0]   mode;
        logic [7:0]   opts;
        logic [15:0]  period;
        logic [15:0]  idle;
        logic         pin_s1;
        logic         pin_s2;
        logic         pin_s3;
        power_state_t pwr;
        logic [15:0]  idle_cnt;
        logic [15:0]  sleep_cnt;
        logic         hold;
        logic [16:0]  hold_cnt;
        logic         asleep;
        logic         poll_req;
        logic         sample_req;
        logic         msg_discard;
        rsp_t         rsp;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_RESET = '{
        mode:     MODE_RESET,
        opts:     OPT_RESET,
        period:   PERIOD_RESET,
        idle:     IDLE_RESET,
        idle_cnt: IDLE_RESET,
        pwr:      pwr_awake,
        default:  '0
    };

    // state of the timebase
    typedef struct packed {
        logic [15:0] cyc;
        logic [3:0]  ms;
        logic        tick_ms;
        logic        tick_period;
    } tb_state_t;

    localparam tb_state_t TB_RESET = '{default: '0};

endpackage

// >>> rtl/sleep_timebase.sv
`timescale 1ns/100ps
module sleep_timebase #(
    parameter int unsigned CYC_PER_MS = sleep_ctrl_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // ticks
    output logic      tick_ms,
    output logic      tick_period
);
    import sleep_ctrl_pkg::*;

    localparam logic [15:0] CYC_LAST = 16'(CYC_PER_MS - 1);
    localparam logic [3:0]  MS_LAST  = 4'(MS_PER_PERIOD_UNIT - 1);

    tb_state_t q;  // registered state
    tb_state_t d;  // next state

    // cycle and ms dividers
    always_comb begin
        d             = q;
        d.tick_ms     = 1'b0;
        d.tick_period = 1'b0;
        if (q.cyc == CYC_LAST) begin  // end of a millisecond
            d.cyc     = '0;
            d.tick_ms = 1'b1;
            if (q.ms == MS_LAST) begin  // end of a period unit
                d.ms          = '0;
                d.tick_period = 1'b1;
            end else begin
                d.ms = q.ms + 4'h1;
            end
        end else begin
            d.cyc = q.cyc + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= TB_RESET;
        end else begin
            q <= d;
        end
    end

    assign tick_ms     = q.tick_ms;
    assign tick_period = q.tick_period;

endmodule // sleep_timebase

// >>> bench/host_model.sv
`timescale 1ns/100ps
// host side of the command port: one request at a time
module host_model (
    // clock
    input  wire logic                 core_clk,
    // command port
    output sleep_ctrl_pkg::cmd_t      cmd,
    input  wire sleep_ctrl_pkg::rsp_t rsp
);
    import sleep_ctrl_pkg::*;

    // idle port from time zero
    initial begin
        cmd = '0;
    end

    // one-cycle request on a falling edge, answer taken on the next falling
    // edge, half a cycle after the taking edge; a few spare cycles before giving up
    task automatic xfer(input logic wr, input param_sel_t s, input logic [15:0] d,
                        output rsp_t r);
        int k;
        @(negedge core_clk);
        cmd <= '{valid: 1'b1, write: wr, sel: s, data: d};
        @(negedge core_clk);
        cmd <= '0;
        k = 0;
        while (rsp.valid !== 1'b1 && k < 4) begin
            @(negedge core_clk);
            k++;
        end
        r = rsp;
    endtask
endmodule // host_model

// >>> bench/sleep_mode_control_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
// drives the sleep controller and checks its answers and status pins
module sleep_mode_control_tb;
    import sleep_ctrl_pkg::*;
    logic        core_clk, rstn;            // clock and reset
    cmd_t        cmd;                       // host request
    rsp_t        rsp, r;                    // answer, last taken answer
    logic        s_act, r_act, pin, adc_en; // traffic, pin, sampling
    logic        coord_en, queued, deliv;   // coordinator message inputs
    logic        asleep, poll, sample;      // status pins
    logic        discard, holding;          // held message status
    int          n_errors, check_count;     // verdict counters
    int          seed, cyc, i, n;           // seed, cycles, loop, wait count
    logic [31:0] d;                         // random word
    logic [15:0] shadow [4];                // expected parameter values
    logic [17:0] tbl [9];                   // {selector, value} boundaries
    logic [15:0] awake_m [5];               // modes that never time out

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    host_model host (.core_clk, .cmd, .rsp);

    sleep_mode_control #(.CYC_PER_MS(4)) DUT (
        .core_clk, .rstn, .cmd, .rsp,
        .serial_activity(s_act), .radio_activity(r_act), .sleep_pin(pin),
        .adc_sampling_en(adc_en), .coordinator_enable(coord_en),
        .msg_queued(queued), .msg_delivered(deliv), .asleep, .poll_req(poll),
        .sample_req(sample), .msg_discard(discard), .msg_holding(holding)
    );

    // refusal by field range
    function automatic logic refuse(input param_sel_t s, input logic [15:0] v);
        case (s)
            sleep_mode_command:    return v > 16'h0006;
            sleep_options_command: return v > 16'h0004;
            sleep_period_command:  return v > 16'h68b0;
            default:               return v == 16'h0000;
        endcase
    endfunction

    // one command, answer against the shadow copy
    task automatic cmdck(input logic wr, input param_sel_t s, input logic [15:0] v);
        logic bad;
        bad = wr & refuse(s, v);
        host.xfer(wr, s, v, r);
        `CHK("rsp valid", 1'b1, r.valid)
        `CHK("rsp error", bad, r.error)
        `CHK("rsp data", shadow[s], r.data)
        if (wr && !bad) shadow[s] = v;
    endtask

    // bounded wait for asleep (0) or discard (1) to reach a level
    task automatic wait_on(input int w, input logic lv, input int lim);
        n = 0;
        while ((w == 0 ? asleep : discard) !== lv && n < lim) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // one-cycle pulse of queued (0) or delivered (1)
    task automatic pulse(input logic w);
        @(negedge core_clk);
        if (w) deliv = 1'b1;
        else queued = 1'b1;
        @(negedge core_clk);
        {queued, deliv} = 2'b00;
        @(negedge core_clk);
    endtask

    task automatic report(input string nm);
        $display("test %s done, errors so far %0d", nm, n_errors);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_errors++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        {rstn, s_act, r_act, pin, adc_en, coord_en, queued, deliv} = '0;
        seed = 33833;
        n_errors = 0;
        check_count = 0;
        cyc = 0;
        shadow = '{16'h0000, 16'h0000, 16'h0064, 16'h1388};
        tbl = '{18'h10004, 18'h10005, 18'h10104, 18'h268b0, 18'h268b1,
                18'h20000, 18'h30000, 18'h3ffff, 18'h30001};
        awake_m = '{16'h0000, 16'h0003, 16'h0006, 16'h0002, 16'h0001};
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        // reset values, then every mode code and the field boundaries
        for (i = 0; i < 4; i++) cmdck(1'b0, param_sel_t'(i), 16'hffff);
        for (i = 0; i < 8; i++) cmdck(1'b1, sleep_mode_command, 16'(i));
        for (i = 0; i < 9; i++) cmdck(1'b1, param_sel_t'(tbl[i][17:16]), tbl[i][15:0]);
        // random writes, half with small values, then read all back
        for (i = 0; i < 24; i++) begin
            d = $random(seed);
            cmdck(1'b1, param_sel_t'(d[17:16]), d[20] ? d[15:0] : 16'(d[3:0]));
        end
        for (i = 0; i < 4; i++) cmdck(1'b0, param_sel_t'(i), 16'h0000);
        report("ranges");
        // idle 1 ms, period 2 units; these modes never time out
        cmdck(1'b1, idle_time_command, 16'h0001);
        cmdck(1'b1, sleep_period_command, 16'h0002);
        for (i = 0; i < 5; i++) begin
            cmdck(1'b1, sleep_mode_command, awake_m[i]);
            repeat (2) @(negedge core_clk);
            wait_on(0, 1'b1, 80);
            `CHK("stays awake", 1'b0, asleep)
        end
        report("awake modes");
        // cyclic sleep; traffic holds it off, each option pair on wake
        adc_en = 1'b1;
        r_act = 1'b1;
        cmdck(1'b1, sleep_mode_command, 16'h0004);
        wait_on(0, 1'b1, 60);
        `CHK("busy awake", 1'b0, asleep)
        for (i = 0; i < 4; i++) begin
            cmdck(1'b1, sleep_options_command, 16'(i));
            {s_act, r_act} = 2'b00;
            wait_on(0, 1'b1, 40);
            `CHK("idle sleep", 1'b1, asleep)
            wait_on(0, 1'b0, 100);
            `CHK("period length", 1'b1, n >= 38 && n <= 85)
            `CHK("wake poll", ~i[0], poll)
            `CHK("wake sample", ~i[1], sample)
            {s_act, r_act} = {i[0], ~i[0]};
        end
        report("cyclic");
        // pin modes: sample on wake only with sampling enabled, never a poll
        cmdck(1'b1, sleep_options_command, 16'h0000);
        for (i = 1; i < 3; i++) begin
            cmdck(1'b1, sleep_mode_command, 16'(i));
            adc_en = i[0];
            pin = 1'b1;
            wait_on(0, 1'b1, 10);
            `CHK("pin sleep", 1'b1, asleep)
            pin = 1'b0;
            wait_on(0, 1'b0, 10);
            `CHK("pin sample", i[0], sample)
            `CHK("pin poll", 1'b0, poll)
        end
        // cyclic with pin wake: pin release ends the sleep early, sample only
        adc_en = 1'b1;
        cmdck(1'b1, sleep_mode_command, 16'h0005);
        pin = 1'b1;
        {s_act, r_act} = 2'b00;
        wait_on(0, 1'b1, 40);
        `CHK("cyclic pin sleep", 1'b1, asleep)
        pin = 1'b0;
        wait_on(0, 1'b0, 10);
        `CHK("pin wake early", 1'b1, asleep === 1'b0 && n <= 4)
        `CHK("pin wake sample", 1'b1, sample)
        `CHK("pin wake poll", 1'b0, poll)
        s_act = 1'b1;
        report("pin modes");
        // coordinator by its enable, equal settings; discard at 2.5 periods
        cmdck(1'b1, idle_time_command, 16'hffff);
        cmdck(1'b1, sleep_mode_command, 16'h0004);
        coord_en = 1'b1;
        pulse(1'b0);
        `CHK("holding", 1'b1, holding)
        wait_on(1, 1'b1, 260);
        `CHK("discard time", 1'b1, discard === 1'b1 && n >= 150 && n <= 215)
        @(negedge core_clk);
        `CHK("hold cleared", 1'b0, holding)
        // delivered message is never discarded
        pulse(1'b0);
        repeat (20) @(negedge core_clk);
        pulse(1'b1);
        wait_on(1, 1'b1, 250);
        `CHK("no discard", 1'b0, discard)
        `CHK("delivered", 1'b0, holding)
        // period zero sends direct, nothing held
        cmdck(1'b1, sleep_period_command, 16'h0000);
        pulse(1'b0);
        `CHK("direct", 1'b0, holding)
        report("hold");
        give_verdict();
    end
endmodule // sleep_mode_control_tb
